// ### bench/acs_host_model.sv
// Purpose: host serial port model that drives command frames into the sequencer
// Assumes: link clock of 64 ns, standing low between frames
// Notes:   records SAMPLE_SWITCH late in every half period of a frame
`default_nettype none
module acs_host_model
(
   output var  logic        SELECT_N,
   output var  logic        IO_CLK,
   output var  logic        DATA_IN,
   output var  logic        FRAME_SYNC,
   output var  logic        CLOCK_INVERT_SELECT,
   input  wire logic        SAMPLE_SWITCH,
   output var  logic [20:0] sw_trace
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      SELECT_N = 1'b1;
      IO_CLK = 1'b0;
      DATA_IN = 1'b0;
      FRAME_SYNC = 1'b1;
      CLOCK_INVERT_SELECT = 1'b1;
      sw_trace = '0;
   end

   // ten link clocks; data moves on the edge opposite the capture edge
   task automatic frame(input logic [3:0] code, input logic mp, input logic inv);
      int   b;
      logic fall_cap;
      fall_cap = (mp != inv);
      FRAME_SYNC = mp;
      CLOCK_INVERT_SELECT = inv;
      DATA_IN = fall_cap ? ~code[3] : code[3];
      #7.3;
      SELECT_N = 1'b0;
      #36;
      for (int e = 1; e <= 20; e++)
      begin
         #4;
         IO_CLK = ~IO_CLK;
         b = fall_cap ? (e + 1) / 2 - 1 : e / 2;
         if (fall_cap == e[0])
            DATA_IN = (b < 4) ? code[3 - b] : ~DATA_IN;
         #28;
         sw_trace[e] = SAMPLE_SWITCH;
      end
      SELECT_N = 1'b1;
      DATA_IN = ~DATA_IN;
      FRAME_SYNC = 1'b1;
   endtask : frame
endmodule : acs_host_model
`default_nettype wire

// ### bench/acs_top_tb.sv
// Purpose: self-checking bench for the converter command sequencer
// Assumes: host model drives the link; bench is bus master and comparator
// Notes:   comparator answers from a bench-held input level
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
   $display("Error at %0t: got %h expected %h", $time, g, e); end end
module acs_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        SYS_CLK = 1'b0;
   logic        RST = 1'b1;
   logic        HSEL = 1'b0;
   logic        HWRITE = 1'b0;
   logic [1:0]  HTRANS = 2'h0;
   logic [31:0] HADDR = 32'h0;
   logic [31:0] HWDATA = 32'h0;
   logic        SAMPLE_START_N = 1'b1;
   logic        COMPARATOR_LOW = 1'b0;
   logic [31:0] HRDATA;
   logic        HREADYOUT, HRESP, SAMPLE_SWITCH, CONV_BUSY, POWER_DOWN;
   logic        SELECT_N, IO_CLK, DATA_IN, FRAME_SYNC, CLOCK_INVERT_SELECT;
   logic [10:0] MUX_SELECT;
   logic [9:0]  TRIAL_WORD;
   logic [20:0] sw_trace;
   logic [31:0] rd;
   logic [9:0]  vin = 10'h0;
   logic [9:0]  res = 10'h0;
   logic        fast = 1'b1, pd = 1'b0, md = 1'b1, en = 1'b1, async_f = 1'b0, have = 1'b0;
   int          bad_count = 0;
   int          samples_checked = 0;
   int          midx = 0;
   int          cnt;

   always #2 SYS_CLK = ~SYS_CLK;

   // keep the trial bit while the input level is at or above the trial word
   always @(posedge SYS_CLK) COMPARATOR_LOW <= (TRIAL_WORD <= vin);

   acs_top acs_top_inst (.SYS_CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2),
      .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .SELECT_N, .IO_CLK,
      .DATA_IN, .FRAME_SYNC, .CLOCK_INVERT_SELECT, .SAMPLE_START_N, .COMPARATOR_LOW,
      .MUX_SELECT, .SAMPLE_SWITCH, .TRIAL_WORD, .CONV_BUSY, .POWER_DOWN);

   acs_host_model host_inst (.SELECT_N, .IO_CLK, .DATA_IN, .FRAME_SYNC,
      .CLOCK_INVERT_SELECT, .SAMPLE_SWITCH, .sw_trace);

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up

   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge SYS_CLK);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HADDR <= {24'h0, a};
      HWRITE <= wr;
      for (int p = 0; p < 2; p++)
      begin
         n = 0;
         do
         begin
            @(posedge SYS_CLK);
            n++;
         end
         while (HREADYOUT !== 1'b1 && n < 50);
         if (HREADYOUT !== 1'b1)
         begin
            bad_count++;
            wrap_up;
         end
         if (p == 0)
         begin
            HSEL <= 1'b0;
            HTRANS <= 2'h0;
            HWDATA <= wd;
         end
      end
      rd = HRDATA;
      `CHK(HRESP, 1'b0)
   endtask : ahb

   task automatic wait_idle;
      cnt = 0;
      while (CONV_BUSY !== 1'b0 && cnt < 12000)
      begin
         @(posedge SYS_CLK);
         cnt++;
      end
      if (cnt >= 12000)
      begin
         bad_count++;
         wrap_up;
      end
   endtask : wait_idle

   task automatic run(input logic [3:0] code, input logic mp, input logic inv,
                      input logic [9:0] v);
      logic samp;
      vin = v;
      samp = en && !async_f && !(code inside {4'h8, 4'h9, 4'ha, 4'he, 4'hf});
      if (en)
      begin
         md = mp;
         if (code < 4'h8)
            midx = code;
         if (code inside {[4'hb:4'hd]})
            midx = code - 3;
         pd = (code == 4'h8);
         if (code == 4'h9)
            fast = 1'b1;
         if (code == 4'ha)
            fast = 1'b0;
      end
      host_inst.frame(code, mp, inv);
      async_f = 1'b0;
      `CHK(sw_trace, samp ? (mp ? 21'h0fff80 : 21'h0fff00) : 21'h0)
      `CHK(MUX_SELECT, 11'h1 << midx)
      `CHK(POWER_DOWN, pd)
      `CHK(CONV_BUSY, samp)
      if (samp)
      begin
         ahb(1'b0, 8'h08, 32'h0);
         if (have)
            `CHK(rd[9:0], res)
         wait_idle;
         `CHK((cnt + 50) / 100, fast ? 25 : 100)
         res = v;
         have = 1'b1;
      end
      ahb(1'b0, 8'h08, 32'h0);
      if (have)
         `CHK(rd[9:0], res)
      ahb(1'b0, 8'h04, 32'h0);
      `CHK({rd[7], rd[5:4]}, {md, pd, fast})
      $display("test code %h done", code);
   endtask : run

   initial
   begin
      void'($urandom(32'h94ef));
      repeat (3) @(posedge SYS_CLK);
      RST <= 1'b0;
      repeat (4) @(posedge SYS_CLK);
      `CHK(MUX_SELECT, 11'h001)
      ahb(1'b0, 8'h00, 32'h0);
      `CHK(rd, 32'h1)
      ahb(1'b0, 8'h0c, 32'h0);
      `CHK(rd, 32'h0)
      ahb(1'b0, 8'h04, 32'h0);
      `CHK({rd[7], rd[5:4]}, 3'b101)
      $display("test reset done");
      for (int c = 0; c < 8; c++)
         run(4'(c), 1'b1, 1'b1, 10'($urandom));
      run(4'hb, 1'b1, 1'b0, 10'h200);
      run(4'hc, 1'b0, 1'b1, 10'h000);
      run(4'hd, 1'b0, 1'b0, 10'h3ff);
      run(4'he, 1'b1, 1'b1, 10'h0);
      run(4'hf, 1'b1, 1'b1, 10'h0);
      run(4'h8, 1'b1, 1'b1, 10'h0);
      run(4'h2, 1'b1, 1'b1, 10'($urandom));
      run(4'ha, 1'b1, 1'b1, 10'h0);
      run(4'h5, 1'b1, 1'b1, 10'($urandom));
      run(4'h9, 1'b1, 1'b1, 10'h0);
      ahb(1'b1, 8'h00, 32'h0);
      en = 1'b0;
      run(4'h3, 1'b1, 1'b1, 10'h0);
      ahb(1'b0, 8'h00, 32'h0);
      `CHK(rd, 32'h0)
      ahb(1'b1, 8'h00, 32'h1);
      en = 1'b1;
      vin = 10'($urandom);
      SAMPLE_START_N <= 1'b0;
      repeat (20) @(posedge SYS_CLK);
      `CHK(SAMPLE_SWITCH, 1'b1)
      SAMPLE_START_N <= 1'b1;
      repeat (10) @(posedge SYS_CLK);
      `CHK({SAMPLE_SWITCH, CONV_BUSY}, 2'b01)
      wait_idle;
      res = vin;
      async_f = 1'b1;
      $display("test extended sampling done");
      run(4'h1, 1'b1, 1'b1, 10'($urandom));
      run(4'h1, 1'b1, 1'b1, 10'($urandom));
      wrap_up;
   end
endmodule : acs_top_tb
`default_nettype wire

// ### design/acs_defines.svh
// Purpose: constants for the converter command sequencer
// Assumes: 250 MHz system clock
// Notes:   times in ns, counts derived from them
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

`define ACS_CLK_PERIOD_NS   4
`define ACS_FAST_CONV_NS    10000
`define ACS_SLOW_CONV_NS    40000
`define ACS_RES_BITS        10
`define ACS_FAST_STEP_CYC   ((`ACS_FAST_CONV_NS / `ACS_RES_BITS) / `ACS_CLK_PERIOD_NS)
`define ACS_SLOW_STEP_CYC   ((`ACS_SLOW_CONV_NS / `ACS_RES_BITS) / `ACS_CLK_PERIOD_NS)
`define ACS_EXT_DELAY_CYC   2'd2
`define ACS_CMD_BITS        4
`define ACS_SAMPLE_EDGE     4'h3
`define ACS_HOLD_EDGE       4'h9
`define ACS_CONV_EDGE       4'ha
`define ACS_CNT_MAX         4'hf
`define ACS_CMD_PDOWN       4'h8
`define ACS_CMD_FAST        4'h9
`define ACS_CMD_SLOW        4'ha
`define ACS_CMD_TEST_MID    4'hb
`define ACS_CMD_TEST_LO     4'hc
`define ACS_CMD_TEST_HI     4'hd
`define ACS_MSB_TRIAL       10'h200
`define ACS_REG_CTRL        8'h00
`define ACS_REG_STATUS      8'h04
`define ACS_REG_RESULT      8'h08
`define ACS_CTRL_RESET      32'h0000_0001
`define ACS_PIN_COUNT       7

`endif

// ### design/acs_pkg.sv
// Purpose: types for the converter command sequencer
// Assumes: nothing
// Notes:   status struct is the STATUS register layout, lsb last
`default_nettype none
package acs_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_SAMPLE, ST_EXT_SAMPLE, ST_EXT_WAIT, ST_CONVERT}
      acs_state_e;
   typedef struct packed {
      logic       busy;
      logic       mode_mp;
      logic       async;
      logic       pdown;
      logic       fast;
      logic [3:0] code;
   } acs_status_s;
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] addr;
   } acs_ahb_ap_s;
endpackage : acs_pkg
`default_nettype wire

// ### design/acs_top.sv
// Purpose: command decode and sample/convert sequencing for a 10-bit SAR converter
// Assumes: serial link pins and comparator are asynchronous to SYS_CLK
// Notes:   registers on AHB-Lite, zero wait states
`include "acs_defines.svh"
`default_nettype none
module acs_top
   import acs_pkg::*;
(
   input  wire logic        SYS_CLK,
   input  wire logic        RST,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output var  logic [31:0] HRDATA,
   output var  logic        HREADYOUT,
   output var  logic        HRESP,
   input  wire logic        SELECT_N,
   input  wire logic        IO_CLK,
   input  wire logic        DATA_IN,
   input  wire logic        FRAME_SYNC,
   input  wire logic        CLOCK_INVERT_SELECT,
   input  wire logic        SAMPLE_START_N,
   input  wire logic        COMPARATOR_LOW,
   output var  logic [10:0] MUX_SELECT,
   output var  logic        SAMPLE_SWITCH,
   output var  logic [9:0]  TRIAL_WORD,
   output var  logic        CONV_BUSY,
   output var  logic        POWER_DOWN
);
   localparam int PN = `ACS_PIN_COUNT;

   function automatic logic [10:0] acs_route(input logic [3:0] code);
      logic [10:0] sel;
      sel = 11'h000;
      if (!code[3])
         sel[code[2:0]] = 1'b1;
      else if (code == `ACS_CMD_TEST_MID)
         sel[8] = 1'b1;
      else if (code == `ACS_CMD_TEST_LO)
         sel[9] = 1'b1;
      else if (code == `ACS_CMD_TEST_HI)
         sel[10] = 1'b1;
      return sel;
   endfunction : acs_route

   function automatic logic acs_samples(input logic [3:0] code);
      return (acs_route(code) != 11'h000);
   endfunction : acs_samples

   // two-stage synchronisers, third stage only for edge finding
   logic [PN-1:0] pin_raw;
   logic [PN-1:0] s1_reg;
   logic [PN-1:0] s2_reg;
   logic [PN-1:0] s3_reg;
   assign pin_raw = {COMPARATOR_LOW, SAMPLE_START_N, CLOCK_INVERT_SELECT, FRAME_SYNC,
                     DATA_IN, IO_CLK, SELECT_N};
   genvar gi;
   generate
      for (gi = 0; gi < PN; gi++)
      begin : g_sync
         always_ff @(posedge SYS_CLK)
         begin
            s1_reg[gi] <= pin_raw[gi];
            s2_reg[gi] <= s1_reg[gi];
            s3_reg[gi] <= s2_reg[gi];
         end
      end
   endgenerate

   wire sel_fall  = s3_reg[0] & ~s2_reg[0];
   wire sel_rise  = ~s3_reg[0] & s2_reg[0];
   wire clk_rise  = ~s3_reg[1] & s2_reg[1];
   wire clk_fall  = s3_reg[1] & ~s2_reg[1];
   wire din       = s2_reg[2];
   wire fsync     = s2_reg[3];
   wire ck_sel    = s2_reg[4];
   wire start_n   = s2_reg[5];
   wire start_fall = s3_reg[5] & ~s2_reg[5];
   wire start_rise = ~s3_reg[5] & s2_reg[5];
   wire cmp_low   = s2_reg[6];

   // bus-side registers
   acs_ahb_ap_s ap_reg;
   logic [31:0] ctrl_reg;
   logic [9:0]  result_reg;
   wire         enable = ctrl_reg[0];

   // link-side state
   acs_state_e  state_reg;
   acs_state_e  state_next;
   logic        mode_mp_reg;
   logic        async_reg;
   logic [3:0]  rise_cnt_reg;
   logic [3:0]  fall_cnt_reg;
   logic [2:0]  bit_cnt_reg;
   logic [3:0]  shift_reg;
   logic [3:0]  code_reg;
   logic        fast_reg;
   logic [1:0]  wait_cnt_reg;
   logic [11:0] step_cnt_reg;
   logic [9:0]  weight_reg;

   wire active     = ~s2_reg[0] & enable;
   wire dsp_reset  = active & ~mode_mp_reg & clk_fall & fsync;
   wire cap_edge   = active & ((mode_mp_reg == ck_sel) ? clk_rise : clk_fall);
   wire cmd_done   = cap_edge & (bit_cnt_reg == 3'd3);
   wire [3:0] code_full = {shift_reg[2:0], din};
   wire [3:0] cur_code  = cmd_done ? code_full : code_reg;
   wire norm_ok    = start_n & ~async_reg;
   wire samp_edge  = mode_mp_reg ? (clk_rise & (rise_cnt_reg == `ACS_SAMPLE_EDGE))
                                 : (clk_fall & (fall_cnt_reg == `ACS_SAMPLE_EDGE));
   wire samp_evt   = active & norm_ok & samp_edge & acs_samples(cur_code);
   wire hold_evt   = active & clk_fall & (fall_cnt_reg == `ACS_HOLD_EDGE);
   wire conv_ok    = (rise_cnt_reg >= `ACS_CONV_EDGE);
   wire [11:0] step_len = fast_reg ? 12'(`ACS_FAST_STEP_CYC) : 12'(`ACS_SLOW_STEP_CYC);
   wire step_tick  = (state_reg == ST_CONVERT) & (step_cnt_reg == step_len - 12'd1);
   wire [9:0] kept = cmp_low ? TRIAL_WORD : (TRIAL_WORD & ~weight_reg);
   wire last_bit   = weight_reg[0];

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
            if (start_fall & enable)
               state_next = ST_EXT_SAMPLE;
            else if (samp_evt)
               state_next = ST_SAMPLE;
         ST_SAMPLE:
            if (sel_rise | dsp_reset | (cmd_done & ~acs_samples(code_full)))
               state_next = ST_IDLE;
            else if (hold_evt)
               state_next = conv_ok ? ST_CONVERT : ST_IDLE;
         ST_EXT_SAMPLE:
            if (start_rise)
               state_next = ST_EXT_WAIT;
         ST_EXT_WAIT:
            if (wait_cnt_reg == `ACS_EXT_DELAY_CYC - 2'd1)
               state_next = ST_CONVERT;
         ST_CONVERT:
            if (step_tick & last_bit)
               state_next = ST_IDLE;
         default:
            state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
         state_reg <= ST_IDLE;
      else
         state_reg <= state_next;
   end

   // frame edge counting and command capture
   always_ff @(posedge SYS_CLK)
   begin
      if (RST || sel_fall || dsp_reset)
      begin
         rise_cnt_reg <= 4'h0;
         fall_cnt_reg <= 4'h0;
         bit_cnt_reg  <= 3'd0;
      end
      else if (active)
      begin
         if (clk_rise && rise_cnt_reg != `ACS_CNT_MAX)
            rise_cnt_reg <= rise_cnt_reg + 4'h1;
         if (clk_fall && fall_cnt_reg != `ACS_CNT_MAX)
            fall_cnt_reg <= fall_cnt_reg + 4'h1;
         if (cap_edge && bit_cnt_reg != 3'(`ACS_CMD_BITS))
            bit_cnt_reg <= bit_cnt_reg + 3'd1;
      end
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
         shift_reg <= 4'h0;
      else if (cap_edge && bit_cnt_reg != 3'(`ACS_CMD_BITS))
         shift_reg <= code_full;
   end

   // command decode: codes E and F fall through every branch
   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
      begin
         code_reg   <= 4'h0;
         fast_reg   <= 1'b1;
         MUX_SELECT <= 11'h001;
         POWER_DOWN <= 1'b0;
      end
      else
      begin
         if (sel_fall && enable)
            POWER_DOWN <= 1'b0;
         if (cmd_done)
         begin
            code_reg <= code_full;
            if (acs_samples(code_full))
               MUX_SELECT <= acs_route(code_full);
            if (code_full == `ACS_CMD_PDOWN)
               POWER_DOWN <= 1'b1;
            if (code_full == `ACS_CMD_FAST)
               fast_reg <= 1'b1;
            if (code_full == `ACS_CMD_SLOW)
               fast_reg <= 1'b0;
         end
      end
   end

   // mode latch and read-out-only flag for extended conversions
   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
      begin
         mode_mp_reg <= 1'b1;
         async_reg   <= 1'b0;
      end
      else
      begin
         if (sel_fall)
            mode_mp_reg <= fsync;
         if (state_reg == ST_EXT_WAIT)
            async_reg <= 1'b1;
         else if (sel_rise && enable)
            async_reg <= 1'b0;
      end
   end

   // successive approximation
   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
      begin
         step_cnt_reg <= 12'h000;
         weight_reg   <= 10'h000;
         TRIAL_WORD   <= 10'h000;
         result_reg   <= 10'h000;
      end
      else if (state_reg != ST_CONVERT)
      begin
         step_cnt_reg <= 12'h000;
         weight_reg   <= `ACS_MSB_TRIAL;
         TRIAL_WORD   <= `ACS_MSB_TRIAL;
      end
      else if (step_tick)
      begin
         step_cnt_reg <= 12'h000;
         weight_reg   <= weight_reg >> 1;
         TRIAL_WORD   <= kept | (weight_reg >> 1);
         if (last_bit)
            result_reg <= kept;
      end
      else
         step_cnt_reg <= step_cnt_reg + 12'h001;
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (RST || state_reg != ST_EXT_WAIT)
         wait_cnt_reg <= 2'd0;
      else
         wait_cnt_reg <= wait_cnt_reg + 2'd1;
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
      begin
         SAMPLE_SWITCH <= 1'b0;
         CONV_BUSY     <= 1'b0;
      end
      else
      begin
         SAMPLE_SWITCH <= (state_next == ST_SAMPLE) || (state_next == ST_EXT_SAMPLE);
         CONV_BUSY     <= (state_next == ST_CONVERT) || (state_next == ST_EXT_WAIT);
      end
   end

   // AHB-Lite slave: data registered at address phase, zero wait states
   acs_status_s status;
   assign status = '{busy: CONV_BUSY, mode_mp: mode_mp_reg, async: async_reg,
                     pdown: POWER_DOWN, fast: fast_reg, code: code_reg};
   wire        ap_take = HSEL & HTRANS[1] & HREADY;
   wire [7:0]  ap_addr = HADDR[7:0];
   wire [31:0] rd_word = (ap_addr == `ACS_REG_CTRL)   ? ctrl_reg :
                         (ap_addr == `ACS_REG_STATUS) ? {23'h0, status} :
                         (ap_addr == `ACS_REG_RESULT) ? {22'h0, result_reg} : 32'h0;

   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
      begin
         ap_reg    <= '0;
         HRDATA    <= 32'h0;
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end
      else
      begin
         ap_reg    <= '{valid: ap_take, write: HWRITE, addr: ap_addr};
         HRDATA    <= (ap_take && !HWRITE) ? rd_word : 32'h0;
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
         ctrl_reg <= `ACS_CTRL_RESET;
      else if (ap_reg.valid && ap_reg.write && ap_reg.addr == `ACS_REG_CTRL)
         ctrl_reg <= {31'h0, HWDATA[0]};
   end

   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   a_cmd_capture: assert property (cmd_done |=> code_reg == $past(code_full))
      else $error("command word not captured");
   a_edge_choice: assert property ((active & clk_fall & (mode_mp_reg == ck_sel)
         & ~sel_fall & ~dsp_reset) |=> $stable(bit_cnt_reg))
      else $error("captured on wrong serial edge");
   a_chan_route: assert property ((cmd_done & ~code_full[3])
         |=> MUX_SELECT == (11'h001 << $past(code_full[2:0])))
      else $error("external channel not routed");
   a_pdown_cycle: assert property ((cmd_done & code_full == `ACS_CMD_PDOWN)
         |=> POWER_DOWN)
      else $error("power-down not entered");
   a_pdown_wake: assert property ((sel_fall & enable & ~cmd_done) |=> !POWER_DOWN)
      else $error("power-down not left on select");
   a_rate_set: assert property ((cmd_done & (code_full == `ACS_CMD_FAST
         || code_full == `ACS_CMD_SLOW)) |=> fast_reg == $past(~code_full[1]))
      else $error("conversion rate not set");
   a_test_route: assert property ((cmd_done & code_full == `ACS_CMD_TEST_HI)
         |=> MUX_SELECT[10] && $onehot(MUX_SELECT))
      else $error("upper test level not routed");
   a_reserved_idle: assert property ((cmd_done & code_full[3:1] == 3'b111)
         |=> $stable(MUX_SELECT) && $stable(fast_reg))
      else $error("reserved code changed settings");
   a_sample_start: assert property ((state_reg == ST_IDLE & ~start_fall & samp_evt)
         |=> state_reg == ST_SAMPLE ##1 SAMPLE_SWITCH)
      else $error("sampling did not start");
   a_hold_convert: assert property ((state_reg == ST_SAMPLE & hold_evt & conv_ok
         & ~sel_rise & ~dsp_reset & ~cmd_done) |=> state_reg == ST_CONVERT)
      else $error("no conversion after hold");
   a_sar_msb: assert property ((state_reg != ST_CONVERT ##1 state_reg == ST_CONVERT)
         |-> TRIAL_WORD == `ACS_MSB_TRIAL && weight_reg == `ACS_MSB_TRIAL)
      else $error("conversion does not start at msb");
   a_result_hold: assert property ((state_reg == ST_CONVERT & ~(step_tick & last_bit))
         |=> $stable(result_reg))
      else $error("result changed before last bit");
   a_ext_delay: assert property ((state_reg == ST_EXT_SAMPLE & start_rise)
         |=> state_reg == ST_EXT_WAIT ##2 state_reg == ST_CONVERT)
      else $error("extended conversion not two cycles after hold");
endmodule : acs_top
`default_nettype wire
